// >>> design/lrc_pkg.sv
package lrc_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses are four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] LDO1_CONTROL_IDX        = 8'h53;
    localparam logic [7:0] LDO2_VOLTAGE_SELECT_IDX = 8'h54;
    localparam logic [7:0] LDO2_CONTROL_IDX        = 8'h55;
    localparam logic [7:0] LDO3_VOLTAGE_SELECT_IDX = 8'h56;
    localparam logic [7:0] LDO3_CONTROL_IDX        = 8'h57;
    localparam logic [7:0] LDO4_VOLTAGE_SELECT_IDX = 8'h58;
    localparam logic [7:0] LDO4_CONTROL_IDX        = 8'h59;
    localparam int         ADDR_LSB                = 2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CLAMP_BIT    = 7;
    localparam int LOWPWR_BIT   = 6;
    localparam int COMP_HI      = 5;
    localparam int COMP_LO      = 4;
    localparam int GOOD_BIT     = 3;
    localparam int DISCH_BIT    = 1;
    localparam int RAMP_BIT     = 0;
    localparam int VCODE_HI     = 5;
    localparam int VCODE_W      = 6;

    // ------------------------------------------------------------
    // Reset / factory defaults
    // ------------------------------------------------------------
    localparam logic [1:0] COMP_FAST     = 2'h0;
    localparam logic       CLAMP_DEF     = 1'h1;
    localparam logic       LOWPWR_DEF    = 1'h0;
    localparam logic       DISCH_DEF     = 1'h1;
    localparam logic       RAMP_DEF      = 1'h0;
    localparam logic [5:0] VCODE_DEF     = 6'h14;

    // ------------------------------------------------------------
    // Voltage transfer, in microvolts
    // ------------------------------------------------------------
    localparam logic [31:0] HI_BASE_UV   = 32'h000C_3500;
    localparam logic [31:0] HI_STEP_UV   = 32'h0000_C350;
    localparam logic [31:0] LO_BASE_UV   = 32'h0006_1A80;
    localparam logic [31:0] LO_STEP_UV   = 32'h0000_30D4;

    localparam logic [1:0] RESP_OKAY     = 2'h0;
    localparam logic [1:0] RESP_SLVERR   = 2'h2;

endpackage : lrc_pkg

// >>> design/lrc_regs.sv
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module lrc_regs
    import lrc_pkg::*;
#(
    parameter int        NUM_LDO  = 4,
    parameter logic [5:0] VCODE_RESET = VCODE_DEF
)
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // AXI4-Lite write address
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    // AXI4-Lite write response
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    output logic [1:0]                s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    input  wire logic [31:0]          s_axi_araddr,
    // AXI4-Lite read data
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    // Regulator status pins, asynchronous
    input  wire logic [NUM_LDO-1:0]   output_good_in,
    input  wire logic [NUM_LDO-1:0]   regulator_on_in,
    // Regulator controls
    output logic [NUM_LDO-1:0]        overvoltage_clamp_on,
    output logic [NUM_LDO-1:0]        auto_low_power_on,
    output logic [NUM_LDO-1:0]        discharge_path_on,
    output logic [NUM_LDO-1:0]        ramp_rate_select,
    output logic [2*NUM_LDO-1:0]      amplifier_compensation_select,
    output logic [VCODE_W*NUM_LDO-1:0] output_voltage_code,
    output logic [32*NUM_LDO-1:0]     output_voltage_uv
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (NUM_LDO != 4)
    begin : g_bad_count
        $error("lrc_regs serves exactly four regulators");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] idx_of(input logic [31:0] addr);
        idx_of = addr[ADDR_LSB+7:ADDR_LSB];
    endfunction : idx_of

    function automatic logic [31:0] volts_uv(input logic [5:0] code, input logic low_range);
        logic [31:0] c;
        c = {26'h0, code};
        if (low_range)
            volts_uv = LO_BASE_UV + c * LO_STEP_UV;
        else
            volts_uv = HI_BASE_UV + c * HI_STEP_UV;
    endfunction : volts_uv

    // ------------------------------------------------------------
    // Status synchronisers
    // ------------------------------------------------------------
    logic [NUM_LDO-1:0] good_meta_q;
    logic [NUM_LDO-1:0] good_q;
    logic [NUM_LDO-1:0] on_meta_q;
    logic [NUM_LDO-1:0] on_q;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            good_meta_q <= '0;
            good_q      <= '0;
            on_meta_q   <= '0;
            on_q        <= '0;
        end
        else
        begin
            good_meta_q <= output_good_in;
            good_q      <= good_meta_q;
            on_meta_q   <= regulator_on_in;
            on_q        <= on_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    logic        aw_held_q;
    logic [7:0]  aw_idx_q;
    logic        w_held_q;
    logic [7:0]  w_data_q;
    logic        w_lane_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        do_write;
    logic        w_hit;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign do_write      = aw_held_q && w_held_q && !bvalid_q;
    assign w_hit         = aw_idx_q >= LDO1_CONTROL_IDX && aw_idx_q <= LDO4_CONTROL_IDX;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            aw_held_q <= 1'b0;
            aw_idx_q  <= 8'h00;
            w_held_q  <= 1'b0;
            w_data_q  <= 8'h00;
            w_lane_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_idx_q  <= idx_of(s_axi_awaddr);
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata[7:0];
                w_lane_q <= s_axi_wstrb[0];
            end
            if (do_write)
            begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= w_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
                bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------
    // Register storage, one control byte per regulator and one voltage byte for regulators two to four
    // ------------------------------------------------------------
    logic [NUM_LDO-1:0] clamp_q;
    logic [NUM_LDO-1:0] lowpwr_q;
    logic [NUM_LDO-1:0] disch_q;
    logic [NUM_LDO-1:0] ramp_q;
    logic [1:0]         comp_q  [NUM_LDO];
    logic [5:0]         vcode_q [NUM_LDO];
    logic               wr_en;

    // Regulator one has no voltage byte in this bank and no compensation field
    assign wr_en = do_write && w_hit && w_lane_q;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clamp_q  <= {NUM_LDO{CLAMP_DEF}};
            lowpwr_q <= {NUM_LDO{LOWPWR_DEF}};
            disch_q  <= {NUM_LDO{DISCH_DEF}};
            ramp_q   <= {NUM_LDO{RAMP_DEF}};
            for (int i = 0; i < NUM_LDO; i++)
            begin
                comp_q[i]  <= COMP_FAST;
                vcode_q[i] <= VCODE_RESET;
            end
        end
        else if (wr_en)
        begin
            for (int i = 0; i < NUM_LDO; i++)
            begin
                if (aw_idx_q == LDO1_CONTROL_IDX + 8'(2 * i))
                begin
                    clamp_q[i]  <= w_data_q[CLAMP_BIT];
                    lowpwr_q[i] <= w_data_q[LOWPWR_BIT];
                    disch_q[i]  <= w_data_q[DISCH_BIT];
                    ramp_q[i]   <= w_data_q[RAMP_BIT];
                    if (i != 0)
                        comp_q[i] <= w_data_q[COMP_HI:COMP_LO];
                end
                if (i != 0 && aw_idx_q == LDO1_CONTROL_IDX + 8'(2 * i - 1))
                    vcode_q[i] <= w_data_q[VCODE_HI:0];
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic [7:0]  rd_byte;
    logic        rd_hit;
    logic [7:0]  ridx;

    assign s_axi_arready = !rvalid_q;
    assign ridx          = idx_of(s_axi_araddr);

    // Reserved bits read zero; software may not rely on that
    always_comb
    begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
        for (int i = 0; i < NUM_LDO; i++)
        begin
            if (ridx == LDO1_CONTROL_IDX + 8'(2 * i))
            begin
                rd_hit              = 1'b1;
                rd_byte[CLAMP_BIT]  = clamp_q[i];
                rd_byte[LOWPWR_BIT] = lowpwr_q[i];
                rd_byte[GOOD_BIT]   = good_q[i];
                rd_byte[DISCH_BIT]  = disch_q[i];
                rd_byte[RAMP_BIT]   = ramp_q[i];
                if (i != 0)
                    rd_byte[COMP_HI:COMP_LO] = comp_q[i];
            end
            if (i != 0 && ridx == LDO1_CONTROL_IDX + 8'(2 * i - 1))
            begin
                rd_hit             = 1'b1;
                rd_byte[VCODE_HI:0] = vcode_q[i];
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_byte};
            rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ------------------------------------------------------------
    // Regulator control outputs
    // ------------------------------------------------------------
    logic [NUM_LDO-1:0] disch_out_q;
    logic [31:0]        uv_q [NUM_LDO];

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            disch_out_q <= '0;
            for (int i = 0; i < NUM_LDO; i++)
                uv_q[i] <= 32'h0000_0000;
        end
        else
        begin
            disch_out_q <= disch_q & ~on_q;
            for (int i = 0; i < NUM_LDO; i++)
                uv_q[i] <= volts_uv(vcode_q[i], i == NUM_LDO - 1);
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_LDO; i++)
        begin
            amplifier_compensation_select[2*i +: 2]   = comp_q[i];
            output_voltage_code[VCODE_W*i +: VCODE_W] = vcode_q[i];
            output_voltage_uv[32*i +: 32]             = uv_q[i];
        end
    end

    assign overvoltage_clamp_on = clamp_q;
    assign auto_low_power_on    = lowpwr_q;
    assign discharge_path_on    = disch_out_q;
    assign ramp_rate_select     = ramp_q;

endmodule : lrc_regs

// >>> tb/lrc_regs_props.sv
`timescale 1ns/1ps
module lrc_regs_props
#(
    parameter int NUM_LDO = 4
)
(
    // Clock and reset
    input wire logic                    mclk,
    input wire logic                    reset_n,
    // Register bus
    input wire logic                    s_axi_awvalid,
    input wire logic                    s_axi_awready,
    input wire logic [31:0]             s_axi_awaddr,
    input wire logic                    s_axi_wvalid,
    input wire logic                    s_axi_wready,
    input wire logic [31:0]             s_axi_wdata,
    input wire logic [3:0]              s_axi_wstrb,
    input wire logic                    s_axi_rvalid,
    input wire logic [31:0]             s_axi_rdata,
    // Regulators
    input wire logic [NUM_LDO-1:0]      regulator_on_in,
    input wire logic [NUM_LDO-1:0]      overvoltage_clamp_on,
    input wire logic [NUM_LDO-1:0]      auto_low_power_on,
    input wire logic [NUM_LDO-1:0]      discharge_path_on,
    input wire logic [NUM_LDO-1:0]      ramp_rate_select,
    input wire logic [2*NUM_LDO-1:0]    amplifier_compensation_select,
    input wire logic [6*NUM_LDO-1:0]    output_voltage_code,
    input wire logic [32*NUM_LDO-1:0]   output_voltage_uv
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Second regulator control write, both items taken together
    // ------------------------------------------------------------
    sequence s_wr_ctl2;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr == 32'h0000_0154 && s_axi_wstrb[0];
    endsequence

    a_clamp_write: assert property (s_wr_ctl2 |-> ##3
        overvoltage_clamp_on[1] == $past(s_axi_wdata[7], 3)) else $error("clamp not stored");
    a_lowpwr_write: assert property (s_wr_ctl2 |-> ##3
        auto_low_power_on[1] == $past(s_axi_wdata[6], 3)) else $error("low power not stored");
    a_ramp_write: assert property (s_wr_ctl2 |-> ##3
        ramp_rate_select[1] == $past(s_axi_wdata[0], 3)) else $error("ramp not stored");
    a_comp_write: assert property (s_wr_ctl2 |-> ##3
        amplifier_compensation_select[3:2] == $past(s_axi_wdata[5:4], 3))
        else $error("compensation not stored");
    a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // Pin is synchronised and restarts at off after reset, so only a settled level is judged
    a_disch_off: assert property (($stable(regulator_on_in) && $past(reset_n)) [*4] |->
        (discharge_path_on & regulator_on_in) == '0) else $error("discharge while on");
    a_ldo2_volts: assert property ($past(reset_n) |-> output_voltage_uv[63:32] ==
        32'h000C_3500 + 32'h0000_C350 * $past(output_voltage_code[11:6]))
        else $error("ldo2 voltage wrong");
    a_ldo3_volts: assert property ($past(reset_n) |-> output_voltage_uv[95:64] ==
        32'h000C_3500 + 32'h0000_C350 * $past(output_voltage_code[17:12]))
        else $error("ldo3 voltage wrong");
    a_ldo4_volts: assert property ($past(reset_n) |-> output_voltage_uv[127:96] ==
        32'h0006_1A80 + 32'h0000_30D4 * $past(output_voltage_code[23:18]))
        else $error("ldo4 voltage wrong");
endmodule : lrc_regs_props

bind lrc_regs lrc_regs_props #(.NUM_LDO(NUM_LDO)) u_props (.*);

// >>> tb/tb.sv
`timescale 1ns/1ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
    import lrc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic         mclk = 1'h0, reset_n = 1'h0;
    logic         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0]  s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    logic [3:0]   s_axi_wstrb = 4'h0, output_good_in = 4'h0, regulator_on_in = 4'h0;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp, resp;
    logic [31:0]  s_axi_rdata, rd_data;
    logic [3:0]   overvoltage_clamp_on, auto_low_power_on, discharge_path_on, ramp_rate_select;
    logic [7:0]   amplifier_compensation_select;
    logic [23:0]  output_voltage_code;
    logic [127:0] output_voltage_uv;
    logic [7:0]   exp_q [0:6];
    int           failures = 0, cmp_count = 0;

    always #2.5 mclk = ~mclk;

    lrc_regs uut (.*);

    // ------------------------------------------------------------
    // Expectations
    // ------------------------------------------------------------
    function automatic logic [7:0] msk(input int i);
        return i == 0 ? 8'hCB : (i % 2 ? 8'h3F : 8'hFB);
    endfunction : msk

    function automatic logic [31:0] volts(input int k, input logic [5:0] c);
        return k == 3 ? 32'h0006_1A80 + c * 32'h0000_30D4 : 32'h000C_3500 + c * 32'h0000_C350;
    endfunction : volts

    // ------------------------------------------------------------
    // Bus tasks, sampled at the falling edge so nothing races the rising one
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic wr(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s);
        bit aw, w, b;
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        b = 0;
        n = 0;
        while (!b)
        begin
            @(negedge mclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge mclk);
            if (aw) s_axi_awvalid <= 1'h0;
            if (w) s_axi_wvalid <= 1'h0;
            if (++n > 40)
            begin
                failures++;
                end_sim();
            end
        end
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [31:0] a);
        bit ar, r;
        int n;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        r = 0;
        n = 0;
        while (!r)
        begin
            @(negedge mclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd_data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge mclk);
            if (ar) s_axi_arvalid <= 1'h0;
            if (++n > 40)
            begin
                failures++;
                end_sim();
            end
        end
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic wreg(input int i, input logic [7:0] d);
        wr(32'h0000_014C + 32'(4 * i), d, 4'h1);
        `CHK(resp, RESP_OKAY, "write response")
        exp_q[i] = d;
    endtask : wreg

    // Reserved read bits are masked off, their value is not defined
    task automatic check_all;
        logic [7:0] e;
        for (int i = 0; i < 7; i++)
        begin
            rd(32'h0000_014C + 32'(4 * i));
            e = exp_q[i];
            if (i % 2 == 0) e[3] = output_good_in[i / 2];
            `CHK(resp, RESP_OKAY, "read response")
            `CHK(rd_data[7:0] & msk(i), e & msk(i), "read value")
        end
        for (int k = 0; k < 4; k++)
        begin
            e = exp_q[2 * k];
            `CHK(overvoltage_clamp_on[k], e[7], "clamp")
            `CHK(auto_low_power_on[k], e[6], "low power")
            `CHK(ramp_rate_select[k], e[0], "ramp")
            `CHK(discharge_path_on[k], e[1] & ~regulator_on_in[k], "discharge")
            if (k > 0)
            begin
                `CHK(amplifier_compensation_select[2*k +: 2], e[5:4], "comp")
                `CHK(output_voltage_code[6*k +: 6], exp_q[2*k-1][5:0], "code")
                `CHK(output_voltage_uv[32*k +: 32], volts(k, exp_q[2*k-1][5:0]), "uv")
            end
        end
    endtask : check_all

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int i;
        logic [7:0] d;
        void'($urandom(2));
        for (int j = 0; j < 7; j++) exp_q[j] = j % 2 ? 8'h14 : 8'h82;
        repeat (3) @(posedge mclk);
        reset_n <= 1'h1;
        check_all();
        repeat (24)
        begin
            i = $urandom_range(6);
            d = 8'($urandom) & msk(i) & (i % 2 ? 8'hFF : 8'hF7);
            regulator_on_in <= 4'($urandom);
            output_good_in <= 4'($urandom);
            wreg(i, d);
            check_all();
        end
        for (int v = 0; v < 2; v++)
        begin
            for (int j = 1; j < 7; j += 2) wreg(j, v ? 8'h3F : 8'h00);
            check_all();
        end
        `CHK(output_voltage_uv[63:32], 32'h003C_45B0, "top code")
        wr(32'h0000_0168, 8'hFF, 4'h1);
        `CHK(resp, RESP_SLVERR, "unmapped write")
        rd(32'h0000_0148);
        `CHK({resp, rd_data}, {RESP_SLVERR, 32'h0}, "unmapped read")
        // Strobe off: answered but nothing stored
        wr(32'h0000_0154, 8'h2A, 4'h0);
        `CHK(resp, RESP_OKAY, "no strobe")
        check_all();
        @(posedge mclk);
        reset_n <= 1'h0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'h1;
        for (int j = 0; j < 7; j++) exp_q[j] = j % 2 ? 8'h14 : 8'h82;
        check_all();
        end_sim();
    end
endmodule : tb
